// File: shared/dpci_pkg.sv
// Purpose: shared constants and types of the pin command interface
// Assumes: four banks, thirteen address inputs
// Notes: mode register bit positions apply to the first extended register
package dpci_pkg;

   // command encodings, DDR2 truth table
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACTIVATE = 3'h1,
      CMD_READ = 3'h2,
      CMD_WRITE = 3'h3,
      CMD_PRECHARGE = 3'h4,
      CMD_REFRESH = 3'h5,
      CMD_MODE_SET = 3'h6,
      CMD_DESELECT = 3'h7
   } dpci_cmd_e;

   // burst engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WRITE = 2'h1,
      ST_READ = 2'h2
   } dpci_state_e;

   localparam int ADDR_W = 13;
   localparam int BANKS = 4;
   localparam int BURST_BEATS = 4;

   // address bit that selects auto-precharge or precharge-all
   localparam int AUTOPRECHARGE_BIT = 10;

   // bank_select codes during a mode set command
   localparam logic [1:0] MR_SEL_BASE = 2'h0;
   localparam logic [1:0] MR_SEL_EXT_ONE = 2'h1;

   // fields of extended_mode_reg_one
   localparam int EXT_SINGLE_ENDED_BIT = 10;
   localparam int EXT_AUX_STROBE_BIT = 11;
   localparam int EXT_TERM_LO_BIT = 2;
   localparam int EXT_TERM_HI_BIT = 6;

   // values after reset, and the final beat values of write and read bursts
   localparam logic [ADDR_W-1:0] MODE_REG_RESET = 13'h0000;
   localparam logic [BANKS-1:0] BANK_OPEN_RESET = 4'h0;
   localparam logic [3:0] LAT_CNT_RESET = 4'h0;
   localparam logic [1:0] BEAT_RESET = 2'h0;
   localparam logic [1:0] LAST_WRITE_PAIR = 2'h2;
   localparam logic [1:0] LAST_READ_BEAT = 2'h3;

endpackage

// File: logic/dpci_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is an independent, slowly changing level
// Notes: the first stage feeds the second stage only
`timescale 1ns/100ps
`default_nettype none
module dpci_sync
#(
   parameter int WIDTH = 1
)
(
   // clocking
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // data
   input wire logic [WIDTH-1:0] d,
   output var logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         stage <= '0;
         q <= '0;
      end
      else if (ce)
      begin
         stage <= d;
         q <= stage;
      end
   end

endmodule
`default_nettype wire

// File: logic/dpci_pin_cmd.sv
// Purpose: device-side command, address and data-path logic of a DDR2 SDRAM pin interface
// Assumes: link clock is the memory clock from the controller; sys_clk hosts status
// Notes: read data leaves one beat per link cycle; write data enters on both link edges
`timescale 1ns/100ps
`default_nettype none
module dpci_pin_cmd
#(
   parameter int DQ_WIDTH = 8,
   parameter int WR_LAT = 1,
   parameter int RD_LAT = 2,
   parameter int ROW_BITS = 2,
   parameter int COL_BITS = 4
)
(
   // system side
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // link clock from the controller
   input wire logic linkClk,
   // command and address pins
   input wire logic chipSelectN,
   input wire logic rowStrobeN,
   input wire logic colStrobeN,
   input wire logic writeStrobeN,
   input wire logic [1:0] bankSelect,
   input wire logic [dpci_pkg::ADDR_W-1:0] addrIn,
   input wire logic dieTerminationCtl,
   // data pins
   input wire logic [DQ_WIDTH-1:0] dqIn,
   output var logic [DQ_WIDTH-1:0] dqOut,
   output var logic dqDriveN,
   // data strobe pins
   output var logic dqsOut,
   output var logic dqsDriveN,
   output var logic dqsCompOut,
   output var logic dqsCompDriveN,
   // mask pin, shared with the auxiliary read strobe
   input wire logic writeByteMask,
   output var logic readAuxStrobeOut,
   output var logic readAuxStrobeCompOut,
   output var logic maskPinDriveN,
   output var logic auxCompDriveN,
   // termination
   output var logic termEnable,
   // status in the sys_clk domain
   output var logic [dpci_pkg::BANKS-1:0] bankOpenSts,
   output var logic burstBusySts,
   output var logic [dpci_pkg::ADDR_W-1:0] modeOpcodeSts,
   output var logic [dpci_pkg::ADDR_W-1:0] extOneOpcodeSts
);

   localparam int IDX_W = 2 + ROW_BITS + COL_BITS;
   localparam int MEM_WORDS = dpci_pkg::BANKS * (2 ** ROW_BITS) * (2 ** COL_BITS);

   if (DQ_WIDTH != 4 && DQ_WIDTH != 8)
   begin : g_chk_width
      $error("dq width must be 4 or 8");
   end
   if (WR_LAT < 1 || WR_LAT > 15 || RD_LAT < 1 || RD_LAT > 15)
   begin : g_chk_lat
      $error("latencies must lie in 1..15");
   end
   if (COL_BITS < 2 || COL_BITS > 11 || ROW_BITS < 1 || ROW_BITS > 13)
   begin : g_chk_addr
      $error("column or row width out of range");
   end

   // link-domain reset and clock enable, carried over from sys_clk levels
   logic linkRstN;
   logic linkCe;

   dpci_sync #(.WIDTH(2)) u_link_sync (
      .clk(linkClk),
      .nrst(1'b1),
      .ce(1'b1),
      .d({nrst, ce}),
      .q({linkRstN, linkCe})
   );

   // link-domain state
   logic [DQ_WIDTH-1:0] mem [MEM_WORDS];
   logic [dpci_pkg::ADDR_W-1:0] modeRegBase;
   logic [dpci_pkg::ADDR_W-1:0] extendedModeRegOne;
   logic modeTgl;
   logic [dpci_pkg::BANKS-1:0] bankOpen;
   logic [ROW_BITS-1:0] openRow [dpci_pkg::BANKS];
   dpci_pkg::dpci_state_e state;
   logic [3:0] latCnt;
   logic [1:0] beat;
   logic [1:0] burstBank;
   logic [ROW_BITS-1:0] burstRow;
   logic [COL_BITS-1:0] burstCol;
   logic burstAp;
   logic [DQ_WIDTH-1:0] riseData;
   logic riseMask;
   logic [DQ_WIDTH-1:0] fallData;
   logic fallMask;

   dpci_pkg::dpci_cmd_e cmd;
   logic singleEnded;
   logic auxOn;
   logic termOn;
   logic maskActive;
   logic burstDone;
   logic writeBeat;
   logic readBeat;

   function automatic dpci_pkg::dpci_cmd_e decodeCmd(input logic csN, input logic rasN,
                                                      input logic casN, input logic weN);
      dpci_pkg::dpci_cmd_e c;
      c = dpci_pkg::CMD_NOP;
      if (csN)
         c = dpci_pkg::CMD_DESELECT;
      else
      begin
         case ({rasN, casN, weN})
            3'h3: c = dpci_pkg::CMD_ACTIVATE;
            3'h5: c = dpci_pkg::CMD_READ;
            3'h4: c = dpci_pkg::CMD_WRITE;
            3'h2: c = dpci_pkg::CMD_PRECHARGE;
            3'h1: c = dpci_pkg::CMD_REFRESH;
            3'h0: c = dpci_pkg::CMD_MODE_SET;
            default: c = dpci_pkg::CMD_NOP;
         endcase
      end
      return c;
   endfunction

   // burst column: low two bits wrap within the four-beat burst
   function automatic logic [IDX_W-1:0] beatIdx(input logic [1:0] b,
                                                input logic [ROW_BITS-1:0] r,
                                                input logic [COL_BITS-1:0] c,
                                                input logic [1:0] n);
      logic [1:0] low;
      low = c[1:0] + n;
      return {b, r, c[COL_BITS-1:2], low};
   endfunction

   always_comb
   begin
      cmd = decodeCmd(chipSelectN, rowStrobeN, colStrobeN, writeStrobeN);
      singleEnded = extendedModeRegOne[dpci_pkg::EXT_SINGLE_ENDED_BIT];
      auxOn = (DQ_WIDTH == 8) && extendedModeRegOne[dpci_pkg::EXT_AUX_STROBE_BIT];
      termOn = extendedModeRegOne[dpci_pkg::EXT_TERM_HI_BIT] |
               extendedModeRegOne[dpci_pkg::EXT_TERM_LO_BIT];
      maskActive = !auxOn;
      writeBeat = (state == dpci_pkg::ST_WRITE) && (latCnt == dpci_pkg::LAT_CNT_RESET);
      readBeat = (state == dpci_pkg::ST_READ) && (latCnt == dpci_pkg::LAT_CNT_RESET);
      burstDone = (writeBeat && beat == dpci_pkg::LAST_WRITE_PAIR) ||
                  (readBeat && beat == dpci_pkg::LAST_READ_BEAT);
   end

   // mode registers, loaded on the rising link edge
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         modeRegBase <= dpci_pkg::MODE_REG_RESET;
         extendedModeRegOne <= dpci_pkg::MODE_REG_RESET;
         modeTgl <= 1'b0;
      end
      else if (linkCe && cmd == dpci_pkg::CMD_MODE_SET)
      begin
         // other register selects are accepted and not stored
         if (bankSelect == dpci_pkg::MR_SEL_BASE)
         begin
            modeRegBase <= addrIn;
            modeTgl <= ~modeTgl;
         end
         else if (bankSelect == dpci_pkg::MR_SEL_EXT_ONE)
         begin
            extendedModeRegOne <= addrIn;
            modeTgl <= ~modeTgl;
         end
      end
   end

   // open bank tracking
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         bankOpen <= dpci_pkg::BANK_OPEN_RESET;
         for (int i = 0; i < dpci_pkg::BANKS; i++)
            openRow[i] <= '0;
      end
      else if (linkCe)
      begin
         if (burstDone && burstAp)
            bankOpen[burstBank] <= 1'b0;
         if (cmd == dpci_pkg::CMD_ACTIVATE)
         begin
            bankOpen[bankSelect] <= 1'b1;
            openRow[bankSelect] <= addrIn[ROW_BITS-1:0];
         end
         else if (cmd == dpci_pkg::CMD_PRECHARGE)
         begin
            if (addrIn[dpci_pkg::AUTOPRECHARGE_BIT])
               bankOpen <= dpci_pkg::BANK_OPEN_RESET;
            else
               bankOpen[bankSelect] <= 1'b0;
         end
      end
   end

   // burst engine; read or write to a closed bank, or while busy, is ignored
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         state <= dpci_pkg::ST_IDLE;
         latCnt <= dpci_pkg::LAT_CNT_RESET;
         beat <= dpci_pkg::BEAT_RESET;
         burstBank <= 2'h0;
         burstRow <= '0;
         burstCol <= '0;
         burstAp <= 1'b0;
      end
      else if (linkCe)
      begin
         case (state)
            dpci_pkg::ST_IDLE:
            begin
               beat <= dpci_pkg::BEAT_RESET;
               if ((cmd == dpci_pkg::CMD_WRITE || cmd == dpci_pkg::CMD_READ) &&
                   bankOpen[bankSelect])
               begin
                  burstBank <= bankSelect;
                  burstRow <= openRow[bankSelect];
                  burstCol <= addrIn[COL_BITS-1:0];
                  burstAp <= addrIn[dpci_pkg::AUTOPRECHARGE_BIT];
                  if (cmd == dpci_pkg::CMD_WRITE)
                  begin
                     state <= dpci_pkg::ST_WRITE;
                     latCnt <= 4'(WR_LAT);
                  end
                  else
                  begin
                     state <= dpci_pkg::ST_READ;
                     latCnt <= 4'(RD_LAT);
                  end
               end
            end
            dpci_pkg::ST_WRITE:
            begin
               if (latCnt != dpci_pkg::LAT_CNT_RESET)
                  latCnt <= latCnt - 4'h1;
               else if (burstDone)
                  state <= dpci_pkg::ST_IDLE;
               else
                  beat <= beat + 2'h2;
            end
            dpci_pkg::ST_READ:
            begin
               if (latCnt != dpci_pkg::LAT_CNT_RESET)
                  latCnt <= latCnt - 4'h1;
               else if (burstDone)
                  state <= dpci_pkg::ST_IDLE;
               else
                  beat <= beat + 2'h1;
            end
            default:
               state <= dpci_pkg::ST_IDLE;
         endcase
      end
   end

   // write beats: rising-edge half here, falling-edge half below
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         riseData <= '0;
         riseMask <= 1'b0;
      end
      else if (linkCe)
      begin
         riseData <= dqIn;
         riseMask <= writeByteMask;
      end
   end

   // the falling edge stands in for the centred write strobe edge
   always_ff @(negedge linkClk)
   begin
      if (!linkRstN)
      begin
         fallData <= '0;
         fallMask <= 1'b0;
      end
      else if (linkCe)
      begin
         fallData <= dqIn;
         fallMask <= writeByteMask;
      end
   end

   // array has no reset; contents are undefined until written
   always_ff @(posedge linkClk)
   begin
      if (linkRstN && linkCe && writeBeat)
      begin
         if (!(riseMask && maskActive))
            mem[beatIdx(burstBank, burstRow, burstCol, beat)] <= riseData;
         if (!(fallMask && maskActive))
            mem[beatIdx(burstBank, burstRow, burstCol, beat + 2'h1)] <= fallData;
      end
   end

   // pin drivers; strobes toggle with each data change, so they stay edge-aligned
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
      begin
         dqOut <= '0;
         dqDriveN <= 1'b1;
         dqsOut <= 1'b0;
         dqsDriveN <= 1'b1;
         dqsCompOut <= 1'b0;
         dqsCompDriveN <= 1'b1;
         readAuxStrobeOut <= 1'b0;
         readAuxStrobeCompOut <= 1'b0;
         maskPinDriveN <= 1'b1;
         auxCompDriveN <= 1'b1;
      end
      else if (linkCe)
      begin
         if (readBeat)
         begin
            dqOut <= mem[beatIdx(burstBank, burstRow, burstCol, beat)];
            dqDriveN <= 1'b0;
            dqsOut <= ~beat[0];
            dqsDriveN <= 1'b0;
            dqsCompOut <= beat[0];
            dqsCompDriveN <= singleEnded;
            readAuxStrobeOut <= ~beat[0];
            readAuxStrobeCompOut <= beat[0];
            maskPinDriveN <= !auxOn;
            auxCompDriveN <= !auxOn || singleEnded;
         end
         else
         begin
            dqOut <= '0;
            dqDriveN <= 1'b1;
            dqsOut <= 1'b0;
            dqsDriveN <= 1'b1;
            dqsCompOut <= 1'b0;
            dqsCompDriveN <= 1'b1;
            readAuxStrobeOut <= 1'b0;
            readAuxStrobeCompOut <= 1'b0;
            maskPinDriveN <= 1'b1;
            auxCompDriveN <= 1'b1;
         end
      end
   end

   // termination follows the registered control only while enabled in the register
   always_ff @(posedge linkClk)
   begin
      if (!linkRstN)
         termEnable <= 1'b0;
      else if (linkCe)
         termEnable <= dieTerminationCtl && termOn;
   end

   // sys_clk side: levels through two flops, op-codes taken on a toggle change
   logic [dpci_pkg::BANKS+1:0] sysSync;
   logic modeTglSeen;

   dpci_sync #(.WIDTH(dpci_pkg::BANKS + 2)) u_sys_sync (
      .clk(sys_clk),
      .nrst(nrst),
      .ce(ce),
      .d({modeTgl, state != dpci_pkg::ST_IDLE, bankOpen}),
      .q(sysSync)
   );

   // op-codes stay still for many link cycles after a mode set, so a late sample is safe
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         modeTglSeen <= 1'b0;
         modeOpcodeSts <= dpci_pkg::MODE_REG_RESET;
         extOneOpcodeSts <= dpci_pkg::MODE_REG_RESET;
         bankOpenSts <= dpci_pkg::BANK_OPEN_RESET;
         burstBusySts <= 1'b0;
      end
      else if (ce)
      begin
         bankOpenSts <= sysSync[dpci_pkg::BANKS-1:0];
         burstBusySts <= sysSync[dpci_pkg::BANKS];
         modeTglSeen <= sysSync[dpci_pkg::BANKS+1];
         if (sysSync[dpci_pkg::BANKS+1] != modeTglSeen)
         begin
            modeOpcodeSts <= modeRegBase;
            extOneOpcodeSts <= extendedModeRegOne;
         end
      end
   end

endmodule
`default_nettype wire

// File: testbench/dpci_pin_cmd_properties.sv
// Purpose: concurrent checks on the pins of the pin command interface
// Assumes: x8 width; mode registers are static while a burst runs
// Notes: status ports lag the link, so mode bits read from them during a burst rely on the registers being static
`timescale 1ns/100ps
`default_nettype none
module dpci_pin_cmd_properties
#(
   parameter int RD_LAT = 2
)
(
   // clock and reset
   input wire logic linkClk,
   input wire logic nrst,
   // command and termination inputs
   input wire logic chipSelectN,
   input wire logic rowStrobeN,
   input wire logic colStrobeN,
   input wire logic writeStrobeN,
   input wire logic dieTerminationCtl,
   // driven pins
   input wire logic dqDriveN,
   input wire logic dqsOut,
   input wire logic dqsDriveN,
   input wire logic dqsCompOut,
   input wire logic dqsCompDriveN,
   input wire logic readAuxStrobeOut,
   input wire logic readAuxStrobeCompOut,
   input wire logic maskPinDriveN,
   input wire logic auxCompDriveN,
   input wire logic termEnable,
   input wire logic [dpci_pkg::ADDR_W-1:0] extOneOpcodeSts
);
   default clocking @(posedge linkClk); endclocking
   default disable iff (!nrst);

   wire logic readCmd = !chipSelectN && rowStrobeN && !colStrobeN && writeStrobeN;

   sequence s_read_issued;
      $past(readCmd, RD_LAT + 2) && dqsOut;
   endsequence
   sequence s_burst;
      (!dqDriveN)[*4] ##1 dqDriveN;
   endsequence

   property p_read_lat;
      $fell(dqDriveN) |-> s_read_issued;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("burst start not tied to read");
   property p_burst_len;
      $fell(dqDriveN) |-> s_burst;
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("burst not four beats");
   property p_strobe_toggle;
      !dqDriveN && !$past(dqDriveN) |-> dqsOut != $past(dqsOut);
   endproperty
   a_strobe_toggle: assert property (p_strobe_toggle) else $error("strobe not edge aligned");
   property p_drive_group;
      (dqDriveN == dqsDriveN) && (!dqsDriveN || (maskPinDriveN && dqsCompDriveN && auxCompDriveN));
   endproperty
   a_drive_group: assert property (p_drive_group) else $error("drive enables disagree");
   property p_comp_enable;
      !dqsDriveN |-> dqsCompDriveN == extOneOpcodeSts[10];
   endproperty
   a_comp_enable: assert property (p_comp_enable) else $error("complement strobe mode wrong");
   property p_comp_level;
      !dqsCompDriveN |-> dqsCompOut != dqsOut;
   endproperty
   a_comp_level: assert property (p_comp_level) else $error("complement strobe not inverse");
   property p_aux;
      !dqsDriveN |-> (maskPinDriveN == !extOneOpcodeSts[11]) && (maskPinDriveN ||
         (readAuxStrobeOut == dqsOut && (auxCompDriveN || readAuxStrobeCompOut == !dqsOut)));
   endproperty
   a_aux: assert property (p_aux) else $error("aux strobe wrong");
   property p_term_off;
      (!dieTerminationCtl)[*3] |-> !termEnable;
   endproperty
   a_term_off: assert property (p_term_off) else $error("termination without request");
   property p_term_on;
      dieTerminationCtl[*3] |-> termEnable == (extOneOpcodeSts[6] || extOneOpcodeSts[2]);
   endproperty
   a_term_on: assert property (p_term_on) else $error("termination gating wrong");
endmodule

bind dpci_pin_cmd dpci_pin_cmd_properties #(.RD_LAT(RD_LAT)) chk
(
   .linkClk(linkClk), .nrst(nrst), .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN),
   .colStrobeN(colStrobeN), .writeStrobeN(writeStrobeN), .dieTerminationCtl(dieTerminationCtl),
   .dqDriveN(dqDriveN), .dqsOut(dqsOut), .dqsDriveN(dqsDriveN), .dqsCompOut(dqsCompOut),
   .dqsCompDriveN(dqsCompDriveN), .readAuxStrobeOut(readAuxStrobeOut),
   .readAuxStrobeCompOut(readAuxStrobeCompOut), .maskPinDriveN(maskPinDriveN),
   .auxCompDriveN(auxCompDriveN), .termEnable(termEnable), .extOneOpcodeSts(extOneOpcodeSts)
);
`default_nettype wire

// File: testbench/dpci_host_model.sv
// Purpose: host controller model making the memory clock, commands and write data
// Assumes: bursts of four; command inputs change on the falling edge
// Notes: write beats move a quarter period after each edge so edges sit mid-eye
`timescale 1ns/100ps
`default_nettype none
module dpci_host_model
#(
   parameter int DQ_WIDTH = 8,
   parameter int RD_LAT = 2
)
(
   // memory clock and command
   output var logic linkClk,
   output var logic chipSelectN,
   output var logic rowStrobeN,
   output var logic colStrobeN,
   output var logic writeStrobeN,
   output var logic [1:0] bankSelect,
   output var logic [12:0] addrIn,
   output var logic dieTerminationCtl,
   // data
   output var logic [DQ_WIDTH-1:0] dqIn,
   output var logic writeByteMask,
   input wire logic [DQ_WIDTH-1:0] dqOut
);
   initial
   begin
      {chipSelectN, rowStrobeN, colStrobeN, writeStrobeN} = 4'hf;
      bankSelect = 2'h0;
      addrIn = 13'h0000;
      dieTerminationCtl = 1'b0;
      dqIn = {DQ_WIDTH{1'b0}};
      writeByteMask = 1'b0;
      linkClk = 1'b0;
      #7;
      forever #16 linkClk = ~linkClk;
   end

   task automatic cmd(input logic cs, input logic [2:0] rcw, input logic [1:0] ba,
                      input logic [12:0] a);
      @(negedge linkClk);
      chipSelectN = cs;
      {rowStrobeN, colStrobeN, writeStrobeN} = rcw;
      bankSelect = ba;
      addrIn = a;
      @(posedge linkClk);
   endtask

   // released command lines go high and bank and address lines flip so a stale value is never read as valid
   task automatic nop;
      @(negedge linkClk);
      {chipSelectN, rowStrobeN, colStrobeN, writeStrobeN} = 4'hf;
      bankSelect = ~bankSelect;
      addrIn = ~addrIn;
   endtask

   task automatic term(input logic v);
      @(negedge linkClk);
      dieTerminationCtl = v;
   endtask

   task automatic write(input logic [1:0] ba, input logic [12:0] a,
                        input logic [4*DQ_WIDTH-1:0] d, input logic [3:0] m);
      cmd(1'b0, 3'h4, ba, a);
      for (int i = 0; i < 4; i++)
      begin
         #8;
         dqIn = d[i*DQ_WIDTH +: DQ_WIDTH];
         writeByteMask = m[i];
         if (i == 0)
            nop();
         @(linkClk);
      end
      #8;
      dqIn = ~dqIn;
      writeByteMask = ~writeByteMask;
   endtask

   task automatic read(input logic [1:0] ba, input logic [12:0] a,
                       output logic [4*DQ_WIDTH-1:0] d);
      cmd(1'b0, 3'h5, ba, a);
      nop();
      repeat (RD_LAT + 1) @(negedge linkClk);
      for (int i = 0; i < 4; i++)
      begin
         d[i*DQ_WIDTH +: DQ_WIDTH] = dqOut;
         @(negedge linkClk);
      end
   endtask
endmodule
`default_nettype wire

// File: testbench/dpci_pin_cmd_bench.sv
// Purpose: self-checking bench of the pin command interface
// Assumes: x8 width, read latency 2; the host model drives the memory side
// Notes: status is compared after a fixed settle, longer than both crossings
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
      end \
   end
module dpci_pin_cmd_bench;
   localparam logic [2:0] ACT = 3'h3;
   localparam logic [2:0] PRE = 3'h2;
   localparam logic [2:0] REFR = 3'h1;
   localparam logic [2:0] SETMODE = 3'h0;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   wire logic linkClk, chipSelectN, rowStrobeN, colStrobeN, writeStrobeN;
   wire logic dieTerminationCtl, writeByteMask;
   wire logic [1:0] bankSelect;
   wire logic [12:0] addrIn;
   wire logic [7:0] dqIn;
   logic [7:0] dqOut;
   logic dqDriveN, dqsOut, dqsDriveN, dqsCompOut, dqsCompDriveN, termEnable;
   logic readAuxStrobeOut, readAuxStrobeCompOut, maskPinDriveN, auxCompDriveN, burstBusySts;
   logic [3:0] bankOpenSts;
   logic [12:0] modeOpcodeSts, extOneOpcodeSts;
   logic [31:0] rd;
   logic [2:0] seen = 3'h0;
   logic busySeen = 1'b0;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   always #2.5 sys_clk = ~sys_clk;

   dpci_host_model host (.linkClk(linkClk), .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN),
      .colStrobeN(colStrobeN), .writeStrobeN(writeStrobeN), .bankSelect(bankSelect),
      .addrIn(addrIn), .dieTerminationCtl(dieTerminationCtl), .dqIn(dqIn),
      .writeByteMask(writeByteMask), .dqOut(dqOut));

   dpci_pin_cmd uut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .linkClk(linkClk),
      .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
      .writeStrobeN(writeStrobeN), .bankSelect(bankSelect), .addrIn(addrIn),
      .dieTerminationCtl(dieTerminationCtl), .dqIn(dqIn), .dqOut(dqOut), .dqDriveN(dqDriveN),
      .dqsOut(dqsOut), .dqsDriveN(dqsDriveN), .dqsCompOut(dqsCompOut),
      .dqsCompDriveN(dqsCompDriveN), .writeByteMask(writeByteMask),
      .readAuxStrobeOut(readAuxStrobeOut), .readAuxStrobeCompOut(readAuxStrobeCompOut),
      .maskPinDriveN(maskPinDriveN), .auxCompDriveN(auxCompDriveN), .termEnable(termEnable),
      .bankOpenSts(bankOpenSts), .burstBusySts(burstBusySts), .modeOpcodeSts(modeOpcodeSts),
      .extOneOpcodeSts(extOneOpcodeSts));

   // sticky record of which pins the device drove, cleared by the tests
   always @(negedge linkClk)
      seen <= seen | {~maskPinDriveN, ~dqsCompDriveN, ~dqDriveN};

   // busy is a sys_clk level, so look at it where it is settled
   always @(negedge sys_clk)
      busySeen <= busySeen | burstBusySts;

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   // status crosses two domains, so wait well past both synchronisers
   task automatic settle;
      repeat (40) @(negedge sys_clk);
   endtask

   task automatic op(input logic cs, input logic [2:0] rcw, input logic [1:0] ba,
                     input logic [12:0] a);
      host.cmd(cs, rcw, ba, a);
      host.nop();
      settle();
   endtask

   initial
   begin
      // reset outlasts three link rises so the link side is cleared too
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      settle();
      op(1'b0, SETMODE, 2'h1, 13'h0044);
      op(1'b0, SETMODE, 2'h0, 13'h0123);
      op(1'b0, SETMODE, 2'h2, 13'h1fff);
      op(1'b1, SETMODE, 2'h0, 13'h0aaa);
      `CHECK("extOneOpcodeSts", 13'h0044, extOneOpcodeSts)
      `CHECK("modeOpcodeSts", 13'h0123, modeOpcodeSts)
      $display("test mode set done");
      op(1'b0, ACT, 2'h1, 13'h0001);
      op(1'b0, ACT, 2'h2, 13'h0001);
      op(1'b1, ACT, 2'h0, 13'h0001);
      op(1'b0, REFR, 2'h3, 13'h0000);
      op(1'b0, 3'h7, 2'h3, 13'h0400);
      `CHECK("bankOpenSts", 4'h6, bankOpenSts)
      op(1'b0, PRE, 2'h1, 13'h1bff);
      `CHECK("bankOpenSts", 4'h4, bankOpenSts)
      op(1'b0, ACT, 2'h0, 13'h0000);
      op(1'b0, PRE, 2'h0, 13'h0400);
      `CHECK("bankOpenSts", 4'h0, bankOpenSts)
      $display("test banks done");
      op(1'b0, ACT, 2'h2, 13'h0001);
      host.write(2'h2, 13'h0002, 32'h44332211, 4'h0);
      host.read(2'h2, 13'h0000, rd);
      `CHECK("read wrap", 32'h22114433, rd)
      `CHECK("comp strobe seen", 1'b1, seen[1])
      `CHECK("busy seen", 1'b1, busySeen)
      host.write(2'h2, 13'h0000, 32'ha4a3a2a1, 4'h5);
      host.read(2'h2, 13'h0400, rd);
      `CHECK("read masked", 32'ha411a233, rd)
      settle();
      `CHECK("bankOpenSts", 4'h0, bankOpenSts)
      // cleared on a rising link edge, away from the sticky update on the falling one
      @(posedge linkClk) seen = 3'h0;
      host.read(2'h2, 13'h0000, rd);
      `CHECK("closed bank drive", 1'b0, seen[0])
      $display("test data path done");
      op(1'b0, SETMODE, 2'h1, 13'h0c44);
      op(1'b0, ACT, 2'h3, 13'h0002);
      host.write(2'h3, 13'h0000, 32'h04030201, 4'hf);
      @(posedge linkClk) seen = 3'h0;
      host.read(2'h3, 13'h0000, rd);
      `CHECK("read mask off", 32'h04030201, rd)
      `CHECK("strobe drives", 3'h5, seen)
      $display("test strobes done");
      host.term(1'b1);
      settle();
      `CHECK("termEnable", 1'b1, termEnable)
      host.term(1'b0);
      op(1'b0, SETMODE, 2'h1, 13'h0000);
      host.term(1'b1);
      settle();
      `CHECK("termEnable", 1'b0, termEnable)
      host.term(1'b0);
      $display("test termination done");
      settle();
      ce = 1'b0;
      settle();
      op(1'b0, ACT, 2'h1, 13'h0001);
      ce = 1'b1;
      settle();
      `CHECK("ce freeze", 4'h8, bankOpenSts)
      $display("test clock enable done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
